// >>> logic/ata_set_features_identify.sv
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`include "ata_sf_consts.svh"

module ata_set_features_identify
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write address and data
   input  wire logic [7:0]        awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // axi4-lite write response
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // axi4-lite read
   input  wire logic [7:0]        araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // reset straps, sampled at reset release
   input  wire logic              dasp_seen,
   input  wire logic              pdiag_seen,
   input  wire logic              diag_passed,
   input  wire logic [1:0]        devnum_method,
   input  wire logic              cblid_high,
   // drive events
   input  wire logic              soft_reset,
   input  wire logic              unlock_failed,
   input  wire logic              flush_done,
   // drive controls
   output logic                   flush_req,
   output logic                   cmd_abort,
   output ata_sf_pkg::feat_s      feat
);
   import ata_sf_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   function automatic feat_s por_defaults();
      feat_s f;
      f = '0;
      return f;
   endfunction

   // ----------------------------------------------------------------
   // bus write side
   // ----------------------------------------------------------------
   logic        aw_full;
   logic        w_full;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_be;
   logic        wr_go;
   logic        wr_ok;
   sf_state_e   state;
   taskfile_s   tf;
   logic        exec;
   logic [31:0] tf_word;

   assign awready = !aw_full;
   assign wready  = !w_full;
   assign wr_go   = aw_full && w_full && !bvalid;
   assign tf_word = merge(32'h0000_0000, w_data, w_be);
   assign tf      = {tf_word[7:0], tf_word[15:8], tf_word[23:16]};
   // a new command while a flush is pending is refused
   assign exec    = wr_go && aw_addr == `OFS_TASKFILE
                    && state == ST_IDLE;

   always_comb
   begin
      unique case (aw_addr)
         `OFS_TASKFILE: wr_ok = state == ST_IDLE;
         `OFS_SECURITY, `OFS_ID_FEED, `OFS_ID_CLEAR: wr_ok = 1'b1;
         default:       wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full <= 1'b0;
         w_full  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_be    <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= `RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_full <= 1'b1;
            aw_addr <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_full <= 1'b1;
            w_data <= wdata;
            w_be   <= wstrb;
         end
         if (wr_go)
         begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // set features decode
   // ----------------------------------------------------------------
   logic [4:0] xtype;
   logic [2:0] xmode;
   logic       is_sf;
   logic       sec_expired;
   logic       sec_abort;

   assign xtype     = tf.count[7:3];
   assign xmode     = tf.count[2:0];
   assign is_sf     = tf.command == `CMD_SET_FEAT;
   assign sec_abort = sec_expired && (tf.command == `CMD_SEC_UNLOCK
                      || tf.command == `CMD_SEC_ERASE);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         feat <= por_defaults();
      else if (exec && is_sf)
      begin
         unique case (tf.feature)
            `FT_8BIT_ON:    feat.bus8 <= 1'b1;
            `FT_8BIT_OFF:   feat.bus8 <= 1'b0;
            `FT_WCACHE_ON:  feat.wcache <= 1'b1;
            `FT_WCACHE_OFF: feat.wcache <= 1'b0;
            `FT_APM_ON:     feat.apm <= 1'b1;
            `FT_APM_OFF:    feat.apm <= 1'b0;
            `FT_EPO_ON:     feat.epo <= 1'b1;
            `FT_EPO_OFF:    feat.epo <= 1'b0;
            `FT_RLA_ON:     feat.rla <= 1'b1;
            `FT_RLA_OFF:    feat.rla <= 1'b0;
            `FT_POR_SET:    feat.por_on_srst <= 1'b0;
            `FT_KEEP_SET:   feat.por_on_srst <= 1'b1;
            `FT_XFER_MODE:
            begin
               // only pio modes touch pio_mode, so one stays chosen
               unique case (xtype)
                  `XT_DEFAULT:
                  begin
                     if (xmode <= `XM_IORDY_OFF)
                     begin
                        feat.pio_mode  <= 3'h0;
                        feat.iordy_off <= xmode[0];
                     end
                  end
                  `XT_PIO_FC:
                  begin
                     feat.pio_mode  <= xmode;
                     feat.iordy_off <= 1'b0;
                  end
                  `XT_MWDMA:
                  begin
                     feat.mwdma_sel  <= 1'b1;
                     feat.mwdma_mode <= xmode;
                     feat.udma_sel   <= 1'b0;
                  end
                  `XT_UDMA:
                  begin
                     feat.udma_sel   <= 1'b1;
                     feat.udma_mode  <= xmode;
                     feat.mwdma_sel  <= 1'b0;
                  end
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
      // inverted flag: zero after power-on means defaults return
      else if (soft_reset && !feat.por_on_srst)
         feat <= por_defaults();
   end

   // ----------------------------------------------------------------
   // command status and cache flush
   // ----------------------------------------------------------------
   logic known_ft;
   logic bad_ft;

   always_comb
   begin
      unique case (tf.feature)
         `FT_8BIT_ON, `FT_WCACHE_ON, `FT_APM_ON, `FT_EPO_ON,
         `FT_RLA_OFF, `FT_KEEP_SET, `FT_NOP_A, `FT_8BIT_OFF,
         `FT_WCACHE_OFF, `FT_APM_OFF, `FT_EPO_OFF, `FT_NOP_B,
         `FT_NOP_C, `FT_RLA_ON, `FT_POR_SET: known_ft = 1'b1;
         `FT_XFER_MODE:
            known_ft = xtype == `XT_PIO_FC || xtype == `XT_MWDMA
                       || xtype == `XT_UDMA
                       || (xtype == `XT_DEFAULT
                           && xmode <= `XM_IORDY_OFF);
         default: known_ft = 1'b0;
      endcase
   end

   // non set-features commands other than security pass untouched
   assign bad_ft = (is_sf && !known_ft) || sec_abort;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cmd_abort <= 1'b0;
      else if (exec)
         cmd_abort <= bad_ft;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state     <= ST_IDLE;
         flush_req <= 1'b0;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
               if (exec && is_sf && tf.feature == `FT_WCACHE_OFF)
               begin
                  // completion waits on the flush to non-volatile media
                  state     <= ST_FLUSH;
                  flush_req <= 1'b1;
               end
            ST_FLUSH:
               if (flush_done)
               begin
                  state     <= ST_IDLE;
                  flush_req <= 1'b0;
               end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // reset result straps and security
   // ----------------------------------------------------------------
   logic        rst_seen;
   logic [15:0] rr_word;
   logic [15:0] sec_cfg;
   logic [2:0]  tries_left;
   logic [31:0] sec_word;

   assign sec_word = merge({16'h0000, sec_cfg}, w_data, w_be);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rst_seen <= 1'b0;
         rr_word  <= 16'h0000;
      end
      else if (!rst_seen)
      begin
         // straps are caught once, in the first cycle after release
         rst_seen <= 1'b1;
         rr_word  <= {1'b0, 1'b1, cblid_high, 5'h00, 1'b0, 1'b0,
                      dasp_seen, pdiag_seen,
                      diag_passed,
                      devnum_method,
                      1'b1};
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sec_cfg <= 16'h0000;
      else if (wr_go && aw_addr == `OFS_SECURITY)
         sec_cfg <= sec_word[15:0];
   end

   // only a hard reset brings the attempt count back
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tries_left <= `SEC_TRIES;
      else if (unlock_failed && tries_left != 3'h0)
         tries_left <= tries_left - 3'h1;
   end

   assign sec_expired = tries_left == 3'h0;

   // ----------------------------------------------------------------
   // identify checksum accumulator
   // ----------------------------------------------------------------
   logic [7:0] id_sum;
   logic [7:0] id_chk;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         id_sum <= 8'h00;
      else if (wr_go && aw_addr == `OFS_ID_CLEAR)
         id_sum <= 8'h00;
      else if (wr_go && aw_addr == `OFS_ID_FEED)
         id_sum <= id_sum + w_data[7:0] + w_data[15:8];
   end

   assign id_chk = 8'h00 - (id_sum + `ID_SIGNATURE);

   // ----------------------------------------------------------------
   // bus read side
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rresp  <= `RESP_OKAY;
         unique case (araddr)
            `OFS_TASKFILE:   rdata <= 32'h0000_0000;
            `OFS_STATUS:     rdata <= {30'h0, cmd_abort, flush_req};
            `OFS_FEATURES:   rdata <= {14'h0000, feat};
            `OFS_RST_RESULT: rdata <= {16'h0000, rr_word};
            `OFS_SECURITY:   rdata <= {23'h0, sec_cfg[8],
                                       2'b00, sec_cfg[5],
                                       sec_expired,
                                       sec_cfg[3:0]};
            `OFS_ROTATION:   rdata <= {16'h0000, `ROT_RATE};
            `OFS_INTEGRITY:  rdata <= {16'h0000, id_chk,
                                       `ID_SIGNATURE};
            default:
            begin
               rdata <= 32'h0000_0000;
               rresp <= `RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid && rready)
         rvalid <= 1'b0;
   end

   assign arready = !rvalid;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_sf(logic [7:0] code);
      exec && is_sf && tf.feature == code;
   endsequence

   sequence s_read(logic [7:0] ofs);
      arvalid && arready && araddr == ofs;
   endsequence

   property p_rr_fields;
      s_read(`OFS_RST_RESULT) ##0 rst_seen |=> rdata[5:0] ==
         {$past(rr_word[5]), $past(rr_word[4]), $past(rr_word[3:1]), 1'b1};
   endproperty
   a_rr_fields: assert property (p_rr_fields)
      else $error("reset result read mismatch");

   property p_rr_strap;
      $rose(rst_seen) |-> rr_word[5:1] ==
         {$past(dasp_seen), $past(pdiag_seen), $past(diag_passed),
          $past(devnum_method)};
   endproperty
   a_rr_strap: assert property (p_rr_strap)
      else $error("straps not captured");

   property p_rot;
      s_read(`OFS_ROTATION) |=> rvalid && rdata == 32'h0000_0001;
   endproperty
   a_rot: assert property (p_rot)
      else $error("rotation word wrong");

   property p_chk;
      s_read(`OFS_INTEGRITY) |=> rdata[7:0] == 8'hA5
         && 8'(rdata[15:8] + rdata[7:0] + $past(id_sum)) == 8'h00;
   endproperty
   a_chk: assert property (p_chk)
      else $error("integrity checksum wrong");

   property p_sec_abort;
      exec && sec_expired && tf.command == `CMD_SEC_UNLOCK
         |=> cmd_abort ##1 sec_expired;
   endproperty
   a_sec_abort: assert property (p_sec_abort)
      else $error("unlock not aborted after expiry");

   property p_8bit;
      s_sf(`FT_8BIT_ON) |=> feat.bus8 && !cmd_abort;
   endproperty
   a_8bit: assert property (p_8bit)
      else $error("8-bit mode not set");

   property p_flush;
      s_sf(`FT_WCACHE_OFF) |=> flush_req && !feat.wcache
         && state == ST_FLUSH;
   endproperty
   a_flush: assert property (p_flush)
      else $error("cache disable did not flush");

   property p_udma;
      s_sf(`FT_XFER_MODE) ##0 xtype == `XT_UDMA |=> feat.udma_sel
         && !feat.mwdma_sel && feat.udma_mode == $past(xmode);
   endproperty
   a_udma: assert property (p_udma)
      else $error("ultra dma mode not selected");

   property p_rla;
      s_sf(`FT_RLA_ON) |=> feat.rla ##1 feat.rla || $past(exec)
         || $past(soft_reset);
   endproperty
   a_rla: assert property (p_rla)
      else $error("look-ahead not enabled");

   property p_bad;
      exec && is_sf && !known_ft |=> cmd_abort && $stable(feat);
   endproperty
   a_bad: assert property (p_bad)
      else $error("unknown feature not aborted");

   property p_srst;
      !exec && soft_reset && !feat.por_on_srst |=> feat == '0;
   endproperty
   a_srst: assert property (p_srst)
      else $error("soft reset kept settings");
endmodule

// >>> logic/ata_sf_consts.svh
`ifndef ATA_SF_CONSTS_SVH
`define ATA_SF_CONSTS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_TASKFILE   8'h00
`define OFS_STATUS     8'h04
`define OFS_FEATURES   8'h08
`define OFS_RST_RESULT 8'h0C
`define OFS_SECURITY   8'h10
`define OFS_ROTATION   8'h14
`define OFS_INTEGRITY  8'h18
`define OFS_ID_FEED    8'h1C
`define OFS_ID_CLEAR   8'h20
// ----------------------------------------------------------------
// command and feature codes
// ----------------------------------------------------------------
`define CMD_SET_FEAT   8'hEF
`define CMD_SEC_UNLOCK 8'hF2
`define CMD_SEC_ERASE  8'hF4
`define FT_8BIT_ON     8'h01
`define FT_WCACHE_ON   8'h02
`define FT_XFER_MODE   8'h03
`define FT_APM_ON      8'h05
`define FT_EPO_ON      8'h09
`define FT_RLA_OFF     8'h55
`define FT_KEEP_SET    8'h66
`define FT_NOP_A       8'h69
`define FT_8BIT_OFF    8'h81
`define FT_WCACHE_OFF  8'h82
`define FT_APM_OFF     8'h85
`define FT_EPO_OFF     8'h89
`define FT_NOP_B       8'h96
`define FT_NOP_C       8'h97
`define FT_RLA_ON      8'hAA
`define FT_POR_SET     8'hCC
// ----------------------------------------------------------------
// transfer types, identify, security and bus response constants
// ----------------------------------------------------------------
`define XT_DEFAULT     5'h00
`define XT_PIO_FC      5'h01
`define XT_MWDMA       5'h04
`define XT_UDMA        5'h08
`define XM_IORDY_OFF   3'h1
`define ROT_RATE       16'h0001
`define ID_SIGNATURE   8'hA5
`define SEC_TRIES      3'h5
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// >>> logic/ata_sf_pkg.sv
package ata_sf_pkg;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FLUSH = 2'b01
   } sf_state_e;

   typedef struct packed {
      logic [7:0] command;
      logic [7:0] feature;
      logic [7:0] count;
   } taskfile_s;

   typedef struct packed {
      logic       bus8;
      logic       wcache;
      logic       apm;
      logic       epo;
      logic       rla;
      logic       por_on_srst;
      logic [2:0] pio_mode;
      logic       iordy_off;
      logic       mwdma_sel;
      logic [2:0] mwdma_mode;
      logic       udma_sel;
      logic [2:0] udma_mode;
   } feat_s;
endpackage

// >>> tb/flush_model.sv
module flush_model
(
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // flush handshake, slow stretches the flush
   input  wire logic slow,
   input  wire logic flush_req,
   output logic      flush_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] cnt;

   // a long flush leaves room for a command to collide with it
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !flush_req || flush_done)
      begin
         cnt        <= 5'h00;
         flush_done <= 1'b0;
      end
      else
      begin
         cnt        <= cnt + 5'h01;
         flush_done <= cnt == (slow ? 5'h14 : 5'h01);
      end
   end
endmodule

// >>> tb/testbench.sv
`include "ata_sf_consts.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import ata_sf_pkg::*;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
   logic        bready, arvalid, arready, rvalid, rready, slow;
   logic        dasp_seen, pdiag_seen, diag_passed, cblid_high;
   logic        soft_reset, unlock_failed, flush_done, flush_req, cmd_abort;
   logic [7:0]  awaddr, araddr, rnd, hi, sum;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, devnum_method;
   feat_s       feat, m;
   logic [33:0] exp_r[$];
   logic [1:0]  exp_b[$];
   int          fail_count, total_checks, cycles;

   ata_set_features_identify i_ata_set_features_identify
   (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .dasp_seen(dasp_seen), .pdiag_seen(pdiag_seen),
      .diag_passed(diag_passed), .devnum_method(devnum_method),
      .cblid_high(cblid_high), .soft_reset(soft_reset),
      .unlock_failed(unlock_failed), .flush_done(flush_done),
      .flush_req(flush_req), .cmd_abort(cmd_abort), .feat(feat)
   );
   flush_model i_flush_model
   (
      .aclk(aclk), .aresetn(aresetn), .slow(slow),
      .flush_req(flush_req), .flush_done(flush_done)
   );

   // --------
   // checking
   // --------
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task cmp_r(input logic [33:0] got, input logic [33:0] want);
      total_checks++;
      if (got !== want)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h want %h", $time, got, want);
      end
   endtask
   task cmp_b(input logic [1:0] got, input logic [1:0] want);
      total_checks++;
      if (got !== want)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h want %h", $time, got, want);
      end
   endtask
   // sampled half a cycle early: same values the next edge will take
   always @(negedge aclk)
   begin
      if (rvalid === 1'b1 && rready === 1'b1)
         cmp_r({rresp, rdata}, exp_r.pop_front());
      if (bvalid === 1'b1 && bready === 1'b1)
         cmp_b(bresp, exp_b.pop_front());
   end
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         tally_and_finish;
      end
   end

   // --------
   // bus and stimulus
   // --------
   function logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task wr(input logic [7:0] a, input logic [31:0] d,
           input logic [1:0] e = `RESP_OKAY);
      logic ta, tw, tb;
      exp_b.push_back(e);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      tb = 1'b0;
      while (!tb)
      begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid & bready;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] d,
           input logic [1:0] e = `RESP_OKAY);
      logic ta, tr;
      exp_r.push_back({e, d});
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      tr = 1'b0;
      while (!tr)
      begin
         @(negedge aclk);
         ta = arvalid & arready;
         tr = rvalid & rready;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end
   endtask
   task tf(input logic [7:0] c, input logic [7:0] f, input logic [7:0] n);
      wr(`OFS_TASKFILE, {8'h00, n, f, c});
   endtask
   task sf(input logic [7:0] f, input logic [7:0] n, input logic ab);
      tf(`CMD_SET_FEAT, f, n);
      rd(`OFS_FEATURES, 32'(m));
      rd(`OFS_STATUS, {30'h0, ab, 1'b0});
   endtask
   task pulse(input logic srst);
      if (srst) soft_reset <= 1'b1;
      else unlock_failed <= 1'b1;
      @(posedge aclk);
      soft_reset    <= 1'b0;
      unlock_failed <= 1'b0;
      @(posedge aclk);
   endtask
   task wait_flush;
      for (int i = 0; i < 60 && flush_req !== 1'b0; i++) @(posedge aclk);
   endtask
   task run_tests;
      rd(`OFS_ROTATION, 32'h0000_0001);
      rd(8'h40, 32'h0, `RESP_SLVERR);
      wr(`OFS_ROTATION, 32'h0, `RESP_SLVERR);
      m.bus8 = 1'b1;
      sf(`FT_8BIT_ON, 8'h00, 1'b0);
      m.bus8 = 1'b0;
      sf(`FT_8BIT_OFF, 8'h00, 1'b0);
      m.apm = 1'b1;
      sf(`FT_APM_ON, 8'h00, 1'b0);
      m.epo = 1'b1;
      sf(`FT_EPO_ON, 8'h00, 1'b0);
      m.apm = 1'b0;
      sf(`FT_APM_OFF, 8'h00, 1'b0);
      m.epo = 1'b0;
      sf(`FT_EPO_OFF, 8'h00, 1'b0);
      m.rla = 1'b1;
      sf(`FT_RLA_ON, 8'h00, 1'b0);
      m.rla = 1'b0;
      sf(`FT_RLA_OFF, 8'h00, 1'b0);
      for (int i = 0; i < 3; i++)
         sf(i == 0 ? `FT_NOP_A : i == 1 ? `FT_NOP_B : `FT_NOP_C,
            8'h00, 1'b0);
      sf(8'h44, 8'h00, 1'b1);
      sf(`FT_XFER_MODE, 8'h10, 1'b1);
      sf(`FT_XFER_MODE, 8'h02, 1'b1);
      m.pio_mode = 3'h4;
      sf(`FT_XFER_MODE, 8'h0C, 1'b0);
      m.mwdma_sel  = 1'b1;
      m.mwdma_mode = 3'h2;
      sf(`FT_XFER_MODE, 8'h22, 1'b0);
      m.mwdma_sel = 1'b0;
      m.udma_sel  = 1'b1;
      m.udma_mode = 3'h5;
      sf(`FT_XFER_MODE, 8'h45, 1'b0);
      m.pio_mode  = 3'h0;
      m.iordy_off = 1'b1;
      sf(`FT_XFER_MODE, 8'h01, 1'b0);
      m.iordy_off = 1'b0;
      sf(`FT_XFER_MODE, 8'h00, 1'b0);
      tf(8'h20, `FT_8BIT_ON, 8'h00);
      rd(`OFS_FEATURES, 32'(m));
      m.wcache = 1'b1;
      sf(`FT_WCACHE_ON, 8'h00, 1'b0);
      slow <= 1'b1;
      m.wcache = 1'b0;
      tf(`CMD_SET_FEAT, `FT_WCACHE_OFF, 8'h00);
      rd(`OFS_STATUS, 32'h1);
      wr(`OFS_TASKFILE, {16'h0, `FT_WCACHE_ON, `CMD_SET_FEAT},
         `RESP_SLVERR);
      wait_flush;
      slow <= 1'b0;
      rd(`OFS_FEATURES, 32'(m));
      tf(`CMD_SET_FEAT, `FT_WCACHE_OFF, 8'h00);
      wait_flush;
      rd(`OFS_STATUS, 32'h0);
      m.bus8 = 1'b1;
      sf(`FT_8BIT_ON, 8'h00, 1'b0);
      pulse(1'b1);
      m = '0;
      rd(`OFS_FEATURES, 32'(m));
      m.por_on_srst = 1'b1;
      m.apm         = 1'b1;
      tf(`CMD_SET_FEAT, `FT_KEEP_SET, 8'h00);
      sf(`FT_APM_ON, 8'h00, 1'b0);
      pulse(1'b1);
      rd(`OFS_FEATURES, 32'(m));
      m.por_on_srst = 1'b0;
      sf(`FT_POR_SET, 8'h00, 1'b0);
      pulse(1'b1);
      m = '0;
      rd(`OFS_FEATURES, 32'(m));
      wr(`OFS_SECURITY, 32'h12F);
      rd(`OFS_SECURITY, 32'h12F);
      repeat (4) pulse(1'b0);
      tf(`CMD_SEC_UNLOCK, 8'h00, 8'h00);
      rd(`OFS_STATUS, 32'h0);
      pulse(1'b0);
      rd(`OFS_SECURITY, 32'h13F);
      tf(`CMD_SEC_ERASE, 8'h00, 8'h00);
      rd(`OFS_STATUS, 32'h2);
      tf(`CMD_SEC_UNLOCK, 8'h00, 8'h00);
      rd(`OFS_STATUS, 32'h2);
      wr(`OFS_ID_FEED, 32'h0000_1234);
      wr(`OFS_ID_CLEAR, 32'h0);
      sum = `ID_SIGNATURE;
      repeat (255)
      begin
         hi  = lfsr(rnd);
         rnd = lfsr(hi);
         wr(`OFS_ID_FEED, {16'h0, hi, rnd});
         sum = sum + hi + rnd;
      end
      rd(`OFS_INTEGRITY, {16'h0, 8'h00 - sum, `ID_SIGNATURE});
   endtask
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
      {slow, soft_reset, unlock_failed} <= 3'h0;
      {awaddr, araddr, wdata} <= 48'h0;
      wstrb <= 4'hF;
      rnd = 8'h29;
      m = '0;
      for (int p = 0; p < 2; p++)
      begin
         {dasp_seen, pdiag_seen, diag_passed, devnum_method, cblid_high}
            <= p ? 6'h14 : 6'h2B;
         aresetn <= 1'b0;
         repeat (3) @(posedge aclk);
         aresetn <= 1'b1;
         repeat (2) @(posedge aclk);
         rd(`OFS_RST_RESULT, {16'h0, 2'b01, cblid_high, 7'h00, dasp_seen,
            pdiag_seen, diag_passed, devnum_method, 1'b1});
         rd(`OFS_SECURITY, 32'h0);
         rd(`OFS_FEATURES, 32'h0);
         if (p == 0) run_tests;
      end
      tally_and_finish;
   end
endmodule
